// ### bench/fscd_cpu_model.sv
// Purpose: bus master standing in for the cpu and debug controller
// Assumes: single word transfers, hready from the one slave
// Notes: write data turns to its inverse once its phase ends
`timescale 1ns/1ns
module fscd_cpu_model
(
  // clock and answer
  input wire clk,
  input wire hready,
  input wire [31:0] hrdata,
  // request
  output logic hsel = 1'b0,
  output logic [7:0] haddr = 8'h00,
  output logic [1:0] htrans = 2'b00,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'b000,
  output logic [31:0] hwdata = 32'h0000_0000
);
  logic [31:0] rdat;
  event got;
  // one transfer, begun just after an edge, held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    hwdata <= ~d;
    rdat = hrdata;
    if (!w)
      -> got;
  endtask
endmodule // fscd_cpu_model

// ### bench/fscd_monitor.sv
// Purpose: port checks for the security gate and ratio register
// Assumes: one bus clock, sync active-high reset
// Notes: bound to the top module by name
`timescale 1ns/1ns
module fscd_monitor
(
  // clock, reset, bus
  input wire CLK_SYS,
  input wire RST,
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HRDATA,
  // memory gate and flash side
  input wire MEM_ACCESS,
  input wire MEM_WRITE,
  input wire MEM_FROM_UNSECURED,
  input wire MEM_WRITE_EN,
  input wire [7:0] MEM_RDATA,
  input wire PROG_ERASE_EN,
  input wire CMD_START,
  input wire SECURE,
  input wire ACTIVE_BACKGROUND,
  input wire DEBUG_MODULE_EN,
  // bus answer
  input wire HREADYOUT,
  input wire HRESP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // read taken at this edge, data shows one edge later
  wire rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
  gate_block_a: assert property (SECURE && MEM_ACCESS && MEM_FROM_UNSECURED ##1 SECURE
    |-> !MEM_WRITE_EN && ($past(MEM_WRITE) || MEM_RDATA == 8'h00)) else $error("blocked access leaked");
  gate_open_a: assert property (!SECURE && MEM_ACCESS && MEM_WRITE ##1 !SECURE
    |-> MEM_WRITE_EN) else $error("unsecured write dropped");
  bg_entry_a: assert property ($rose(ACTIVE_BACKGROUND)
    |-> $past(RST) || $past(RST, 2)) else $error("background entered outside reset");
  sec_hold_a: assert property ($rose(SECURE) |-> $past(RST))
    else $error("security came back without reset");
  pe_hold_a: assert property ($fell(PROG_ERASE_EN) |-> $past(RST))
    else $error("loaded flag lost without reset");
  ratio_flag_a: assert property (rd_take && HADDR == 8'h00
    |=> HRDATA[7] == PROG_ERASE_EN) else $error("loaded flag read wrong");
  opt_zero_a: assert property (rd_take && HADDR == 8'h04
    |=> HRDATA[31:8] == 24'h0 && HRDATA[5:2] == 4'h0) else $error("options spare bits set");
  cmd_cause_a: assert property (CMD_START
    |-> $past(HSEL && HTRANS[1] && HWRITE, 2)) else $error("command start without write");
  dbg_lock_a: assert property (SECURE |-> !DEBUG_MODULE_EN)
    else $error("debug module enabled while secure");
  cmd_loaded_a: assert property (CMD_START |-> PROG_ERASE_EN)
    else $error("command start before ratio loaded");
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
endmodule // fscd_monitor

bind fscd_top fscd_monitor u_mon (.*);

// ### bench/fscd_tb_top.sv
// Purpose: self-checking bench for the security gate
// Assumes: 50 MHz clock, two resets with different options
// Notes: reads are noted in a queue and checked on return
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module fscd_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic src_dbg = 1'b0;
  logic src_sec = 1'b1;
  logic [7:0] opt_nv = 8'h7f;
  logic [7:0] prot_nv = 8'h00;
  logic [63:0] key = 64'h0;
  logic bc_done = 1'b0;
  logic bc_erased = 1'b0;
  logic pin = 1'b0;
  logic [2:0] mem_q = 3'b000;
  logic [7:0] mem_raw = 8'h00;
  logic [15:0] lfsr = 16'h62a7;
  logic [31:0] exp_now;
  int n_cmd = 0;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int n;
  wire hsel, hwrite, hready, tick, cmd;
  wire [7:0] haddr;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] hwdata, hrdata;
  always #10 clk_sys = ~clk_sys;
  fscd_top dut (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .SRC_DEBUG(src_dbg), .SRC_SECURE_CODE(src_sec), .OPTIONS_NONVOLATILE_BYTE(opt_nv),
    .PROTECT_NONVOLATILE_BYTE(prot_nv), .UNLOCK_KEY_LOCATIONS(key), .BLANK_CHECK_DONE(bc_done),
    .BLANK_CHECK_ERASED(bc_erased), .DEBUG_MODE_PIN(pin), .MEM_ACCESS(mem_q[0]), .MEM_WRITE(mem_q[1]),
    .MEM_FROM_UNSECURED(mem_q[2]), .MEM_RDATA_RAW(mem_raw), .MEM_WRITE_EN(), .MEM_RDATA(),
    .FLASH_CLK_TICK(tick), .PROG_ERASE_EN(), .CMD_START(cmd), .SECURE(), .DEBUG_MODULE_EN(),
    .ACTIVE_BACKGROUND());
  fscd_cpu_model u_cpu (.clk(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // random memory traffic keeps the gate busy in every state
  always @(posedge clk_sys)
  begin
    lfsr <= nxt(lfsr);
    mem_q <= lfsr[2:0];
    mem_raw <= lfsr[15:8];
    if (rst)
      n_cmd <= 0;
    else if (cmd === 1'b1)
      n_cmd <= n_cmd + 1;
  end
  // returned read data against the oldest note
  always @(u_cpu.got)
  begin
    exp_now = exp_q.pop_front();
    `CHK(u_cpu.rdat, exp_now)
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_cpu.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_cpu.xfer(1'b1, a, d);
  endtask
  // key attempt; bad names a byte to spoil
  task automatic unlock(input logic dbg, input int bad);
    src_dbg <= dbg;
    src_sec <= !dbg;
    wr(8'h08, 32'h0000_0020);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys); // gap between key writes
      wr(8'h10 + 8'(4 * i), {24'h0, key[8 * i +: 8] ^ 8'(i == bad)}); // ascending
    end
    wr(8'h08, 32'h0000_0000);
    src_dbg <= 1'b0;
    src_sec <= 1'b1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200_000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    key = {4{lfsr}} ^ 64'h0123_4567_89ab_cdef;
    prot_nv = lfsr[7:0];
    // pass 0: permit off, pin low; pass 1: permit on, pin high
    for (int p = 0; p < 2; p++)
    begin
      opt_nv <= p ? 8'hff : 8'h7f;
      pin <= p[0];
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(8'h04, {24'h0, opt_nv & 8'hc3});
      rd(8'h30, {30'h0, !pin, 1'b1});
      rd(8'h00, 32'h0);
      rd(8'h3c, 32'h0);
      wr(8'h10, 32'h0000_0000); // no command before the ratio is loaded
      wr(8'h00, 32'h0000_004c); // 2.08 us flash tick period
      wr(8'h00, 32'h0000_0005);
      rd(8'h00, 32'h0000_00cc);
      repeat (2) do @(posedge clk_sys); while (tick !== 1'b1);
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end
      while (tick !== 1'b1);
      `CHK(n, 104)
      wr(8'h0c, {24'h0, ~prot_nv});
      rd(8'h0c, {24'h0, prot_nv});
      src_dbg <= 1'b1;
      wr(8'h0c, 32'h0000_005a);
      rd(8'h0c, 32'h0000_005a);
      src_dbg <= 1'b0;
      wr(8'h10, 32'h0000_0000);
      repeat (3) @(posedge clk_sys);
      `CHK(n_cmd, 1)
      unlock(1'b1, -1);
      rd(8'h30, {30'h0, !pin, 1'b1});
      unlock(1'b0, 3);
      rd(8'h30, {30'h0, !pin, 1'b1});
      unlock(1'b0, -1);
      rd(8'h30, {30'h0, !pin, !p[0]});
      `CHK(n_cmd, 1)
      bc_erased <= 1'b1;
      bc_done <= 1'b1;
      @(posedge clk_sys);
      bc_done <= 1'b0;
      rd(8'h30, {30'h0, !pin, 1'b0});
      bc_erased <= 1'b0;
      $display("pass %0d done", p);
    end
    test_done();
  end
endmodule // fscd_tb_top

// ### hdl/fscd_defines.vh
// Purpose: constants for the flash security gate and clock ratio block
// Assumes: AHB-Lite register window, one aligned 32-bit word per register
// Notes: byte offsets are local to the block's window
`ifndef FSCD_DEFINES_VH
`define FSCD_DEFINES_VH

// register byte offsets
`define FSCD_OFF_RATIO 8'h00
`define FSCD_OFF_OPTIONS 8'h04
`define FSCD_OFF_CONFIG 8'h08
`define FSCD_OFF_PROTECT 8'h0C
`define FSCD_OFF_KEY0 8'h10
`define FSCD_OFF_STATUS 8'h30
`define FSCD_OFF_ERASED 8'h34

// clock ratio register fields
`define FSCD_RATIO_LOADED_BIT 7
`define FSCD_PRESCALE_BIT 6
`define FSCD_RATIO_MSB 5
`define FSCD_RATIO_RESET 8'h00

// options register fields
`define FSCD_UNLOCK_PERMIT_BIT 7
`define FSCD_REDIRECT_DIS_BIT 6
`define FSCD_OPTIONS_MASK 8'hC3

// config register field
`define FSCD_KEY_COMPARE_BIT 5
`define FSCD_CONFIG_RESET 8'h00

// security code values
`define FSCD_SEC_UNSECURED 2'b10

// prescale division and key byte count
`define FSCD_PRESCALE_DIV 4'h8
`define FSCD_PRESCALE_LAST 3'h7
`define FSCD_KEY_BYTES 4'h8

`endif

// ### hdl/fscd_key_cmp.v
// Purpose: sequential compare of the eight written unlock key bytes
// Assumes: bytes arrive in ascending order, one write at a time
// Notes: any out-of-order or wrong byte spoils the whole attempt
`timescale 1ns/1ns
`include "fscd_defines.vh"

module fscd_key_cmp
(
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire start,
  input wire wr,
  input wire [2:0] idx,
  input wire [7:0] data,
  input wire [63:0] key,
  // result
  output wire match
);

  reg [3:0] count_reg;
  reg ok_reg;
  wire [7:0] exp_byte = key[{idx, 3'b000} +: 8];

  // count accepted bytes; an index that skips the order poisons the attempt
  always @(posedge clk)
  begin
    if (rst || start)
    begin
      count_reg <= 4'h0;
      ok_reg <= 1'b1;
    end
    else if (wr)
    begin
      if (count_reg != `FSCD_KEY_BYTES)
        count_reg <= count_reg + 4'h1;
      if (idx != count_reg[2:0] || count_reg == `FSCD_KEY_BYTES || data != exp_byte)
        ok_reg <= 1'b0;
    end
  end

  assign match = ok_reg && (count_reg == `FSCD_KEY_BYTES);

endmodule // fscd_key_cmp

// ### hdl/fscd_top.v
// Purpose: flash and ram security gate with the flash clock ratio register
// Assumes: AHB-Lite slave, single word transfers, bus clock 50 MHz
// Notes: flash command engine, block protection decode and redirection are outside
// Notes: key bytes are write only; the status word at its own offset is a local addition
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "fscd_defines.vh"

module fscd_top
(
  // clock and reset
  input wire CLK_SYS,
  input wire RST,
  // ahb-lite slave
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // access source qualifiers, same clock domain
  input wire SRC_DEBUG,
  input wire SRC_SECURE_CODE,
  // nonvolatile contents; option and protect bytes sampled at reset, key compared live
  input wire [7:0] OPTIONS_NONVOLATILE_BYTE,
  input wire [7:0] PROTECT_NONVOLATILE_BYTE,
  input wire [63:0] UNLOCK_KEY_LOCATIONS,
  // flash array status
  input wire BLANK_CHECK_DONE,
  input wire BLANK_CHECK_ERASED,
  // debug mode pin from outside
  input wire DEBUG_MODE_PIN,
  // memory side
  input wire MEM_ACCESS,
  input wire MEM_WRITE,
  input wire MEM_FROM_UNSECURED,
  input wire [7:0] MEM_RDATA_RAW,
  output reg MEM_WRITE_EN,
  output reg [7:0] MEM_RDATA,
  // flash side
  output reg FLASH_CLK_TICK,
  output reg PROG_ERASE_EN,
  output reg CMD_START,
  output reg SECURE,
  output reg DEBUG_MODULE_EN,
  output reg ACTIVE_BACKGROUND
);

  // software visible registers
  reg [7:0] flash_clock_ratio_reg;
  reg [7:0] options_working_reg;
  reg [7:0] flash_config_reg;
  reg [7:0] protect_working_reg;

  // pin synchroniser flops and the one-shot after reset release
  reg reset_seen_reg;
  reg pin_meta_reg;
  reg pin_sync_reg;

  // data phase copy of the address phase, so writes use the qualifiers of their own transfer
  reg dph_valid_reg;
  reg dph_write_reg;
  reg dph_debug_reg;
  reg dph_secure_reg;
  reg [7:0] dph_addr_reg;

  // prescaler and ratio divider counters
  reg [2:0] pre_count_reg;
  reg [5:0] div_count_reg;

  // security state and its decode
  wire secure_now;
  wire key_enable;
  wire gate_block;
  wire unlock_now;
  wire blank_now;

  // bus decode
  wire addr_phase;
  wire dph_wr;
  wire ratio_wr;
  wire config_wr;
  wire protect_wr;

  // key compare and command start
  wire [7:0] key_off;
  wire key_hit;
  wire key_wr;
  wire key_start;
  wire key_match;
  wire cmd_wr;

  // flash clock prescaler and divider input
  wire pre_tick;
  wire div_in_tick;

  // unsecured only for code 1:0
  assign secure_now = (options_working_reg[1:0] != `FSCD_SEC_UNSECURED);
  assign key_enable = flash_config_reg[`FSCD_KEY_COMPARE_BIT];
  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign dph_wr = dph_valid_reg && dph_write_reg;
  // key bytes sit on word offsets above the first key location
  assign key_off = dph_addr_reg - `FSCD_OFF_KEY0;
  assign key_hit = (dph_addr_reg >= `FSCD_OFF_KEY0) && (key_off < 8'h20);
  assign ratio_wr = dph_wr && (dph_addr_reg == `FSCD_OFF_RATIO);
  assign config_wr = dph_wr && (dph_addr_reg == `FSCD_OFF_CONFIG);
  // protection changes only through background debug commands
  assign protect_wr = dph_wr && dph_debug_reg && (dph_addr_reg == `FSCD_OFF_PROTECT);
  // only secure code may enter key bytes, debug writes are dropped
  assign key_wr = dph_wr && key_hit && key_enable && dph_secure_reg && !dph_debug_reg;
  assign key_start = config_wr && HWDATA[`FSCD_KEY_COMPARE_BIT] && !key_enable;
  // command start needs a loaded ratio, or the flash timing would be undefined
  assign cmd_wr = dph_wr && key_hit && !key_enable
    && flash_clock_ratio_reg[`FSCD_RATIO_LOADED_BIT];
  // unlock: compare bit cleared with a full matching key, and permit set
  assign unlock_now = config_wr && !HWDATA[`FSCD_KEY_COMPARE_BIT] && key_enable && key_match
    && options_working_reg[`FSCD_UNLOCK_PERMIT_BIT];
  assign blank_now = BLANK_CHECK_DONE && BLANK_CHECK_ERASED;
  // secure and from an unsecured source: the access is refused
  assign gate_block = secure_now && MEM_FROM_UNSECURED;

  // byte compare of the entered key
  fscd_key_cmp u_key_cmp
  (
    .clk(CLK_SYS),
    .rst(RST),
    .start(key_start),
    .wr(key_wr),
    .idx(key_off[4:2]),
    .data(HWDATA[7:0]),
    .key(UNLOCK_KEY_LOCATIONS),
    .match(key_match)
  );

  // debug mode pin synchroniser
  // the pin is asynchronous: only the second flop feeds any logic
  always @(posedge CLK_SYS)
  begin
    pin_meta_reg <= DEBUG_MODE_PIN;
    pin_sync_reg <= pin_meta_reg;
  end

  // address phase capture; slave is always ready, zero wait
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      dph_valid_reg <= 1'b0;
      dph_write_reg <= 1'b0;
      dph_debug_reg <= 1'b0;
      dph_secure_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
    end
    else
    begin
      dph_valid_reg <= addr_phase;
      if (addr_phase)
      begin
        dph_write_reg <= HWRITE;
        dph_debug_reg <= SRC_DEBUG;
        dph_secure_reg <= SRC_SECURE_CODE;
        dph_addr_reg <= HADDR;
      end
    end
  end

  // options and protection copied from flash while reset is held
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      options_working_reg <= OPTIONS_NONVOLATILE_BYTE & `FSCD_OPTIONS_MASK;
      protect_working_reg <= PROTECT_NONVOLATILE_BYTE;
    end
    else
    begin
      // key unlock and blank check only ever set the unsecured code, so neither undoes the other
      if (unlock_now)
        options_working_reg[1:0] <= `FSCD_SEC_UNSECURED;
      if (blank_now)
        options_working_reg[1:0] <= `FSCD_SEC_UNSECURED;
      if (protect_wr)
        protect_working_reg <= HWDATA[7:0];
    end
  end

  // config register: only the compare bit is implemented
  always @(posedge CLK_SYS)
  begin
    if (RST)
      flash_config_reg <= `FSCD_CONFIG_RESET;
    else if (config_wr)
      flash_config_reg <= {2'b00, HWDATA[`FSCD_KEY_COMPARE_BIT], 5'b00000};
  end

  // clock ratio register: first write after reset wins, later ones are dropped
  always @(posedge CLK_SYS)
  begin
    if (RST)
      flash_clock_ratio_reg <= `FSCD_RATIO_RESET;
    // bit 7 never comes from the write data, it only records that a write was taken
    else if (ratio_wr && !flash_clock_ratio_reg[`FSCD_RATIO_LOADED_BIT])
      flash_clock_ratio_reg <= {1'b1, HWDATA[6:0]};
  end

  // prescaler: bus clock or bus clock divided by eight
  // it runs free, so the first flash tick after the ratio write may come early
  assign pre_tick = (pre_count_reg == `FSCD_PRESCALE_LAST);
  assign div_in_tick = flash_clock_ratio_reg[`FSCD_PRESCALE_BIT] ? pre_tick : 1'b1;

  always @(posedge CLK_SYS)
  begin
    if (RST)
      pre_count_reg <= 3'b000;
    else
      pre_count_reg <= pre_count_reg + 3'b001;
  end

  // ratio divider: one tick per ratio-plus-one input ticks
  // the compare is >= so a count left above the ratio wraps at once instead of stalling
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      div_count_reg <= 6'h00;
      FLASH_CLK_TICK <= 1'b0;
    end
    else
    begin
      FLASH_CLK_TICK <= 1'b0;
      if (div_in_tick)
      begin
        if (div_count_reg >= flash_clock_ratio_reg[`FSCD_RATIO_MSB:0])
        begin
          div_count_reg <= 6'h00;
          FLASH_CLK_TICK <= 1'b1;
        end
        else
          div_count_reg <= div_count_reg + 6'h01;
      end
    end
  end

  // memory gate; while secure, reads from unsecured source see zeros
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      MEM_WRITE_EN <= 1'b0;
      MEM_RDATA <= 8'h00;
    end
    else
    begin
      // blocked reads give zeros, never a stale byte that could leak secure data
      MEM_WRITE_EN <= MEM_ACCESS && MEM_WRITE && !gate_block;
      MEM_RDATA <= gate_block ? 8'h00 : MEM_RDATA_RAW;
    end
  end

  // background mode latched once, just after reset release, from the synced pin
  // a later pin change has no effect until the next reset
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      reset_seen_reg <= 1'b0;
      ACTIVE_BACKGROUND <= 1'b0;
    end
    else if (!reset_seen_reg)
    begin
      reset_seen_reg <= 1'b1;
      ACTIVE_BACKGROUND <= !pin_sync_reg;
    end
  end

  // status outputs and command start
  // these lag the working state by one edge
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      SECURE <= 1'b1;
      DEBUG_MODULE_EN <= 1'b0;
      PROG_ERASE_EN <= 1'b0;
      CMD_START <= 1'b0;
    end
    else
    begin
      SECURE <= secure_now;
      DEBUG_MODULE_EN <= !secure_now;
      PROG_ERASE_EN <= flash_clock_ratio_reg[`FSCD_RATIO_LOADED_BIT];
      CMD_START <= cmd_wr;
    end
  end

  // read mux, registered into the data phase
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      if (addr_phase && !HWRITE)
      begin
        // key bytes are write only and read as zero like any unmapped offset
        case (HADDR)
          `FSCD_OFF_RATIO: HRDATA <= {24'h00_0000, flash_clock_ratio_reg};
          `FSCD_OFF_OPTIONS: HRDATA <= {24'h00_0000, options_working_reg};
          `FSCD_OFF_CONFIG: HRDATA <= {24'h00_0000, flash_config_reg};
          `FSCD_OFF_PROTECT: HRDATA <= {24'h00_0000, protect_working_reg};
          `FSCD_OFF_STATUS: HRDATA <= {24'h00_0000, 6'h00, ACTIVE_BACKGROUND, secure_now};
          default: HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // fscd_top
